// *** src/smc_pkg.sv ***
// package for the shunt monitor conversion control block
// Summary of operation
// - software reset bit or general-call reset returns everything but the convert pin qualifier to power-up state
// - after reset all status bits masked, warning/over-limit/critical/alert disabled
// - after reset watchdog outputs are active low and transparent
// - mode all ones converts shunt for its average count, then bus, repeating
// - modes 1, 2, 5, 6 convert only shunt or only bus; mode 3 is triggered shunt then bus
// - current and power computed in a multiply step after the last sample, adding MULT_CYC cycles before ready
// - leaving power-down waits 40 us before operation resumes
// - adc-off mode stops all conversions
// - convert input active in triggered modes, low for 4 us starts conversion
// - convert input ignored while a triggered conversion runs
// - triggered conversions still average to programmed shunt and bus counts
// - triggered-mode write with convert held low starts one single-shot conversion
// - result outputs always readable, holding last completed conversion values
// - conversion-ready set only after conversions, averaging and multiply finish
// - configuration write clears ready flag unless mode is power-down or adc-off
// - status read clears the ready flag
// - single-shot start from convert input clears the ready flag
// - signed peak registers hold highest and lowest shunt readings
// - peaks update only from completed conversions
// - in triggered modes ready flag drives the latched alert with faults
package smc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int PWRUP_US = 40;
  localparam int CNV_LOW_US = 4;
  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
  localparam int CNV_LOW_CYC = CNV_LOW_US * CLK_MHZ;
  localparam int SAMPLE_CYC_DEF = 53200; // 532 us per conversion
  localparam int MULT_CYC = 4;
  localparam int CFG_RST_BIT = 15;
  localparam logic [2:0] MODE_PWR_DOWN = 3'h0;
  localparam logic [2:0] MODE_TRIG_SHUNT = 3'h1;
  localparam logic [2:0] MODE_TRIG_BUS = 3'h2;
  localparam logic [2:0] MODE_TRIG_BOTH = 3'h3;
  localparam logic [2:0] MODE_ADC_OFF = 3'h4;
  localparam logic [2:0] MODE_CONT_SHUNT = 3'h5;
  localparam logic [2:0] MODE_CONT_BUS = 3'h6;
  localparam logic [2:0] MODE_CONT_BOTH = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [3:0] AVG_RESET = 4'h3;

  // configuration word written by the host
  typedef struct packed {
    logic rst;
    logic [3:0] bus_averaging_field;
    logic [3:0] shunt_averaging_field;
    logic [2:0] mode;
  } smc_cfg_type;

  // alarm and watchdog setup, all off after reset
  typedef struct packed {
    logic [3:0] status_mask;
    logic warn_en;
    logic over_en;
    logic crit_en;
    logic alert_en;
    logic wd_pol_high;
    logic wd_latched;
  } smc_alarm_type;

  // latest results
  typedef struct packed {
    logic signed [15:0] shunt;
    logic [15:0] bus;
    logic signed [31:0] current;
    logic signed [47:0] power;
  } smc_result_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_WAKE = 6'b000010,
    ST_SHUNT = 6'b000100,
    ST_BUS = 6'b001000,
    ST_MULT = 6'b010000,
    ST_DONE = 6'b100000
  } smc_state_type;
endpackage

// *** src/smc_cnv_qual.sv ***
// convert pin synchroniser and low-time qualifier
`timescale 1ns/1ps
module smc_cnv_qual #(
  parameter int LOW_CYC = smc_pkg::CNV_LOW_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic convert_n_i,
  output logic held_low_o,
  output logic start_o
);
  import smc_pkg::*;
  logic sync1_r, sync2_r, sync1_nxt, sync2_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic held_r, held_nxt;

  // two-stage sync then count continuous low cycles
  always_comb begin
    sync1_nxt = convert_n_i;
    sync2_nxt = sync1_r;
    cnt_nxt = cnt_r;
    held_nxt = held_r;
    if (sync2_r) begin
      cnt_nxt = '0;
      held_nxt = 1'b0;
    end else if (cnt_r < 16'(LOW_CYC - 1)) begin
      cnt_nxt = cnt_r + 16'h0001;
    end else begin
      held_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      cnt_r <= '0;
      held_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      cnt_r <= cnt_nxt;
      held_r <= held_nxt;
    end
  end

  assign held_low_o = held_r;
  assign start_o = held_nxt & ~held_r; // one pulse per qualified low
endmodule

// *** src/smc_conv_ctrl.sv ***
// conversion sequencing, ready flag and peak hold for the shunt monitor
`timescale 1ns/1ps
module smc_conv_ctrl #(
  parameter int SAMPLE_CYC = smc_pkg::SAMPLE_CYC_DEF,
  parameter int PWRUP_WAIT = smc_pkg::PWRUP_CYC,
  parameter int CNV_LOW = smc_pkg::CNV_LOW_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic general_call_rst_i,
  input wire logic cfg_wr_i,
  input wire smc_pkg::smc_cfg_type cfg_wdata_i,
  input wire logic alarm_wr_i,
  input wire smc_pkg::smc_alarm_type alarm_wdata_i,
  input wire logic status_rd_i,
  input wire logic convert_n_i,
  input wire logic signed [15:0] shunt_sample_i,
  input wire logic [15:0] bus_sample_i,
  input wire logic signed [15:0] calib_i,
  input wire logic fault_i,
  output smc_pkg::smc_cfg_type cfg_o,
  output smc_pkg::smc_alarm_type alarm_o,
  output smc_pkg::smc_result_type result_o,
  output logic signed [15:0] peak_high_o,
  output logic signed [15:0] peak_low_o,
  output logic conversion_ready_flag_o,
  output logic alert_o,
  output logic adc_sample_o,
  output logic adc_sel_bus_o,
  output logic analog_on_o,
  output logic busy_o
);
  import smc_pkg::*;

  smc_state_type state_r, state_nxt;
  smc_cfg_type cfg_r, cfg_nxt;
  smc_alarm_type alarm_r, alarm_nxt;
  smc_result_type res_r, res_nxt;
  logic signed [15:0] pk_hi_r, pk_hi_nxt, pk_lo_r, pk_lo_nxt;
  logic signed [31:0] sh_acc_r, sh_acc_nxt;
  logic [31:0] bus_acc_r, bus_acc_nxt;
  logic [31:0] cyc_r, cyc_nxt;
  logic [7:0] smp_r, smp_nxt;
  logic rdy_r, rdy_nxt;
  logic alert_r, alert_nxt;
  logic pk_valid_r, pk_valid_nxt;
  logic pk_upd;
  logic trig_run_r, trig_run_nxt;
  logic pend_r, pend_nxt;
  logic held_low, cnv_start;
  logic soft_rst;
  logic trig_mode, do_shunt, do_bus, sleep_mode;
  logic [7:0] sh_avg, bus_avg;
  logic signed [15:0] sh_mean;
  logic [15:0] bus_mean;

  smc_cnv_qual #(
    .LOW_CYC(CNV_LOW)
  ) u_qual (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .convert_n_i(convert_n_i),
    .held_low_o(held_low),
    .start_o(cnv_start)
  );

  // averaging count from a 4-bit field, powers of two up to 128
  function automatic logic [7:0] avg_count(input logic [3:0] f);
    logic [7:0] n;
    n = 8'h01;
    if (f[3]) begin
      n = 8'h01 << ((f[2:0] > 3'h7) ? 3'h7 : f[2:0]);
    end
    return n;
  endfunction

  // mode decode and averaging; counts are powers of two, so the divide only
  // drops fraction bits and rounds toward zero for negative sums
  assign soft_rst = general_call_rst_i | (cfg_wr_i & cfg_wdata_i.rst);
  assign trig_mode = (cfg_r.mode != MODE_ADC_OFF) & ~cfg_r.mode[2] & (cfg_r.mode != MODE_PWR_DOWN);
  assign do_shunt = cfg_r.mode[0];
  assign do_bus = cfg_r.mode[1];
  assign sleep_mode = (cfg_r.mode == MODE_PWR_DOWN) | (cfg_r.mode == MODE_ADC_OFF);
  assign sh_avg = avg_count(cfg_r.shunt_averaging_field);
  assign bus_avg = avg_count(cfg_r.bus_averaging_field);
  assign sh_mean = 16'(sh_acc_r / $signed({24'h0, sh_avg}));
  assign bus_mean = 16'(bus_acc_r / {24'h0, bus_avg});

  // main sequencer next-state logic
  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    res_nxt = res_r;
    sh_acc_nxt = sh_acc_r;
    bus_acc_nxt = bus_acc_r;
    cyc_nxt = cyc_r;
    smp_nxt = smp_r;
    rdy_nxt = rdy_r;
    alert_nxt = alert_r;
    trig_run_nxt = trig_run_r;
    pend_nxt = pend_r;
    case (state_r)
      ST_IDLE: begin
        cyc_nxt = '0;
        smp_nxt = '0;
        sh_acc_nxt = '0;
        bus_acc_nxt = '0;
        if (!sleep_mode && (!trig_mode || pend_r)) begin
          pend_nxt = 1'b0;
          trig_run_nxt = trig_mode;
          state_nxt = do_shunt ? ST_SHUNT : ST_BUS;
        end
      end
      ST_WAKE: begin
        cyc_nxt = cyc_r + 32'h1;
        if (cyc_r >= 32'(PWRUP_WAIT - 1)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SHUNT: begin
        cyc_nxt = cyc_r + 32'h1;
        if (cyc_r >= 32'(SAMPLE_CYC - 1)) begin
          cyc_nxt = '0;
          sh_acc_nxt = sh_acc_r + 32'(shunt_sample_i);
          smp_nxt = smp_r + 8'h01;
          if (smp_r + 8'h01 >= sh_avg) begin
            smp_nxt = '0;
            state_nxt = do_bus ? ST_BUS : ST_MULT;
          end
        end
      end
      ST_BUS: begin
        cyc_nxt = cyc_r + 32'h1;
        if (cyc_r >= 32'(SAMPLE_CYC - 1)) begin
          cyc_nxt = '0;
          bus_acc_nxt = bus_acc_r + {16'h0, bus_sample_i};
          smp_nxt = smp_r + 8'h01;
          if (smp_r + 8'h01 >= bus_avg) begin
            smp_nxt = '0;
            state_nxt = ST_MULT;
          end
        end
      end
      ST_MULT: begin
        // multiply step after sampling, holds the sequencer for MULT_CYC cycles before done
        cyc_nxt = cyc_r + 32'h1;
        if (cyc_r == 32'h0) begin
          if (do_shunt) begin
            res_nxt.shunt = sh_mean;
            res_nxt.current = 32'(sh_mean * calib_i);
          end
          if (do_bus) begin
            res_nxt.bus = bus_mean;
          end
        end else if (cyc_r == 32'h1) begin
          res_nxt.power = 48'(res_r.current * $signed({1'b0, res_r.bus}));
        end
        if (cyc_r >= 32'(MULT_CYC - 1)) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        rdy_nxt = 1'b1;
        if (trig_run_r) begin
          alert_nxt = 1'b1;
        end
        trig_run_nxt = 1'b0;
        cyc_nxt = '0;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (fault_i && alarm_r.alert_en) begin
      alert_nxt = 1'b1;
    end
    // convert pin only counts in triggered modes and while not converting
    if (cnv_start && trig_mode && !trig_run_nxt && state_r == ST_IDLE) begin
      pend_nxt = 1'b1;
      rdy_nxt = 1'b0;
    end
    if (status_rd_i) begin
      rdy_nxt = 1'b0;
      alert_nxt = 1'b0;
    end
    if (cfg_wr_i) begin
      cfg_nxt = cfg_wdata_i;
      cfg_nxt.rst = 1'b0;
      if (cfg_wdata_i.mode != MODE_PWR_DOWN && cfg_wdata_i.mode != MODE_ADC_OFF) begin
        rdy_nxt = 1'b0;
      end
      if (cfg_wdata_i.mode == MODE_PWR_DOWN || cfg_wdata_i.mode == MODE_ADC_OFF) begin
        state_nxt = ST_IDLE;
        trig_run_nxt = 1'b0;
        pend_nxt = 1'b0;
      end else if (cfg_r.mode == MODE_PWR_DOWN) begin
        state_nxt = ST_WAKE;
        cyc_nxt = '0;
      end
      if (!cfg_wdata_i.mode[2] && cfg_wdata_i.mode != MODE_PWR_DOWN && held_low) begin
        pend_nxt = 1'b1;
        state_nxt = (cfg_r.mode == MODE_PWR_DOWN) ? ST_WAKE : ST_IDLE;
        trig_run_nxt = 1'b0;
      end
    end
  end

  // state registers with reset and soft reset to power-up values
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || soft_rst) begin
      state_r <= ST_IDLE;
      cfg_r <= '{rst: 1'b0, bus_averaging_field: AVG_RESET,
                 shunt_averaging_field: AVG_RESET, mode: MODE_RESET};
      res_r <= '0;
      sh_acc_r <= '0;
      bus_acc_r <= '0;
      cyc_r <= '0;
      smp_r <= '0;
      rdy_r <= 1'b0;
      alert_r <= 1'b0;
      trig_run_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      res_r <= res_nxt;
      sh_acc_r <= sh_acc_nxt;
      bus_acc_r <= bus_acc_nxt;
      cyc_r <= cyc_nxt;
      smp_r <= smp_nxt;
      rdy_r <= rdy_nxt;
      alert_r <= alert_nxt;
      trig_run_r <= trig_run_nxt;
      pend_r <= pend_nxt;
    end
  end

  // alarm setup register, written whole by the host
  always_comb begin
    alarm_nxt = alarm_r;
    if (alarm_wr_i) begin
      alarm_nxt = alarm_wdata_i;
    end
  end

  // every reset leaves all alarm functions masked and off
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || soft_rst) begin
      alarm_r <= '0;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end

  // peak hold sees only completed, averaged shunt readings, so a fast
  // fault that is gone before a conversion ends never shows up here
  assign pk_upd = (state_r == ST_MULT) && (cyc_r == 32'h0) && do_shunt;
  always_comb begin
    pk_hi_nxt = pk_hi_r;
    pk_lo_nxt = pk_lo_r;
    pk_valid_nxt = pk_valid_r;
    if (pk_upd) begin
      pk_valid_nxt = 1'b1;
      // first reading seeds both peaks, whatever its sign
      if (!pk_valid_r || sh_mean > pk_hi_r) begin
        pk_hi_nxt = sh_mean;
      end
      if (!pk_valid_r || sh_mean < pk_lo_r) begin
        pk_lo_nxt = sh_mean;
      end
    end
  end

  // peak registers, cleared by every reset
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || soft_rst) begin
      pk_hi_r <= '0;
      pk_lo_r <= '0;
      pk_valid_r <= 1'b0;
    end else begin
      pk_hi_r <= pk_hi_nxt;
      pk_lo_r <= pk_lo_nxt;
      pk_valid_r <= pk_valid_nxt;
    end
  end

  // outputs straight from registers
  assign cfg_o = cfg_r;
  assign alarm_o = alarm_r;
  assign result_o = res_r;
  assign peak_high_o = pk_hi_r;
  assign peak_low_o = pk_lo_r;
  assign conversion_ready_flag_o = rdy_r;
  assign alert_o = alert_r;
  assign adc_sample_o = ((state_r == ST_SHUNT) || (state_r == ST_BUS)) && (cyc_r == 32'h0);
  assign adc_sel_bus_o = (state_r == ST_BUS);
  assign analog_on_o = (cfg_r.mode != MODE_PWR_DOWN); // off only in power-down
  assign busy_o = (state_r != ST_IDLE);
endmodule

// *** test/smc_trig_model.sv ***
// convert trigger partner driving the low-active convert pin
`timescale 1ns/1ps
module smc_trig_model (
  output logic convert_n_o,
  input wire logic core_clk_i
);
  // idle high, as when the pin is tied high
  initial convert_n_o = 1'b1;
  // low pulse of n cycles, changed off the falling edge
  task pulse(input int n);
    @(negedge core_clk_i);
    convert_n_o = 1'b0;
    repeat (n) @(negedge core_clk_i);
    convert_n_o = 1'b1;
  endtask
  // level control for held-low cases
  task hold(input logic lo);
    @(negedge core_clk_i);
    convert_n_o = ~lo;
  endtask
endmodule

// *** test/smc_sva.sv ***
// port checker for the conversion control block
`timescale 1ns/1ps
module smc_sva
  import smc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic general_call_rst_i,
  input wire logic cfg_wr_i,
  input wire smc_pkg::smc_cfg_type cfg_wdata_i,
  input wire logic status_rd_i,
  input wire smc_pkg::smc_cfg_type cfg_o,
  input wire smc_pkg::smc_alarm_type alarm_o,
  input wire logic signed [15:0] peak_high_o,
  input wire logic signed [15:0] peak_low_o,
  input wire logic conversion_ready_flag_o,
  input wire logic alert_o,
  input wire logic adc_sample_o,
  input wire logic busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // writes that must leave the ready flag alone
  wire logic off_w = cfg_wdata_i.mode inside {MODE_PWR_DOWN, MODE_ADC_OFF};
  wire logic trig_w = cfg_o.mode inside {MODE_TRIG_SHUNT, MODE_TRIG_BUS, MODE_TRIG_BOTH};
  a_reset_vals: assert property ($rose(reset_n_i) |-> cfg_o.mode == MODE_RESET
    && alarm_o == '0 && !conversion_ready_flag_o) else $error("bad reset values");
  a_soft_reset: assert property (general_call_rst_i || (cfg_wr_i && cfg_wdata_i.rst)
    |=> cfg_o.mode == MODE_RESET && alarm_o == '0) else $error("soft reset missed");
  a_rd_clears: assert property (status_rd_i |=> !conversion_ready_flag_o)
    else $error("read left ready set");
  a_wr_clears: assert property (cfg_wr_i && !off_w |=> !conversion_ready_flag_o)
    else $error("write left ready set");
  a_off_keeps: assert property (cfg_wr_i && off_w && !cfg_wdata_i.rst && !status_rd_i
    && !general_call_rst_i && conversion_ready_flag_o |=> conversion_ready_flag_o)
    else $error("off write cleared ready");
  // one cycle of grace while the mode change lands
  a_off_quiet: assert property (cfg_o.mode == MODE_ADC_OFF && $stable(cfg_o.mode)
    |-> !adc_sample_o) else $error("sample while off");
  a_ready_late: assert property ($rose(conversion_ready_flag_o) |-> $past(busy_o))
    else $error("ready without a finished cycle");
  a_alert_trig: assert property ($rose(conversion_ready_flag_o) && trig_w |-> alert_o)
    else $error("no alert on triggered ready");
  a_peak_order: assert property (conversion_ready_flag_o |-> peak_high_o >= peak_low_o)
    else $error("peaks out of order");
endmodule
bind smc_conv_ctrl smc_sva u_sva (.core_clk_i, .reset_n_i, .general_call_rst_i, .cfg_wr_i,
  .cfg_wdata_i, .status_rd_i, .cfg_o, .alarm_o, .peak_high_o, .peak_low_o,
  .conversion_ready_flag_o, .alert_o, .adc_sample_o, .busy_o);

// *** test/shunt_monitor_conversion_control_bench.sv ***
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module shunt_monitor_conversion_control_bench;
  import smc_pkg::*;
  logic clk, rst_n, gc, wr, rd, aw, cnv_n, rdy, alert, smp, selb, aon, busy, flt;
  logic [15:0] bv;
  smc_cfg_type wd, cfg;
  smc_alarm_type awd, al;
  smc_result_type res;
  logic signed [15:0] sh, ph, pl, cal;
  int n_errors, num_checks, ns, nb, n;
  // short counts keep the run brief
  smc_conv_ctrl #(.SAMPLE_CYC(10), .PWRUP_WAIT(5), .CNV_LOW(3)) dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .general_call_rst_i(gc),
    .cfg_wr_i(wr), .cfg_wdata_i(wd), .alarm_wr_i(aw), .alarm_wdata_i(awd),
    .status_rd_i(rd), .convert_n_i(cnv_n), .shunt_sample_i(sh),
    .bus_sample_i(bv), .calib_i(cal), .fault_i(flt),
    .cfg_o(cfg), .alarm_o(al), .result_o(res), .peak_high_o(ph),
    .peak_low_o(pl), .conversion_ready_flag_o(rdy), .alert_o(alert),
    .adc_sample_o(smp), .adc_sel_bus_o(selb), .analog_on_o(aon), .busy_o(busy));
  smc_trig_model tm (.core_clk_i(clk), .convert_n_o(cnv_n));
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // one config write, taken at the next rising edge
  task wrc(input logic r, input logic [2:0] m, input logic [3:0] sa, input logic [3:0] ba);
    @(negedge clk);
    wd = '{r, ba, sa, m};
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task rds();
    @(negedge clk);
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask
  // count shunt and bus samples until ready; bounded
  task wt();
    ns = 0;
    nb = 0;
    repeat (400) begin
      @(negedge clk);
      if (smp === 1'b1 && selb === 1'b1) nb++;
      if (smp === 1'b1 && selb === 1'b0) ns++;
      if (rdy === 1'b1) return;
    end
    chk(1'b0, "ready timeout");
    conclude();
  endtask
  task idle(input int c);
    n = 0;
    repeat (c) begin
      @(negedge clk);
      if (smp === 1'b1) n++;
    end
  endtask
  task t_reset();
    chk(cfg.mode === MODE_RESET && cfg.shunt_averaging_field === AVG_RESET, "cfg");
    chk(cfg.bus_averaging_field === AVG_RESET && al === '0 && rdy === 1'b0, "alarm");
  endtask
  // continuous shunt then bus, two shunt samples averaged
  task t_cont();
    sh = 16'sh0050;
    wrc(1'b0, MODE_ADC_OFF, 4'h3, 4'h3);
    wrc(1'b0, MODE_CONT_BOTH, 4'h9, 4'h3);
    chk(rdy === 1'b0, "wr clear");
    wt();
    chk(ns == 2 && nb == 1, "cont count");
    chk(res.shunt === sh && res.bus === 16'h0123, "result");
    chk(res.current === 32'h000000a0 && res.power === 48'h00000000b5e0, "products");
    chk(ph === sh && pl === sh, "first peak");
  endtask
  // pin-started shunt-only shots, retrigger ignored
  task t_trig();
    wrc(1'b0, MODE_ADC_OFF, 4'h3, 4'h3);
    wrc(1'b0, MODE_TRIG_SHUNT, 4'h9, 4'h3);
    sh = -16'sh0040;
    // count from the pulse's start, as the first sample follows it closely
    fork
      tm.pulse(8);
      wt();
    join
    chk(ns == 2 && nb == 0 && alert === 1'b1, "trig");
    chk(pl === sh && ph === 16'sh0050, "peaks");
    tm.pulse(8);
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(busy === 1'b1 && rdy === 1'b0, "pin clear");
    tm.pulse(8);
    wt();
    idle(30);
    chk(busy === 1'b0 && n == 0, "retrigger");
    rds();
    chk(rdy === 1'b0 && alert === 1'b0, "read clear");
    tm.pulse(1);
    idle(20);
    chk(n == 0 && busy === 1'b0, "glitch");
  endtask
  // pin held low: each triggered-mode write fires one shot
  task t_held();
    wrc(1'b0, MODE_ADC_OFF, 4'h3, 4'h3);
    tm.hold(1'b1);
    idle(10);
    chk(n == 0, "off quiet");
    for (int i = 0; i < 2; i++) begin
      wrc(1'b0, MODE_TRIG_BOTH, 4'h3, 4'h3);
      wt();
      chk(ns == 1 && nb == 1, "held shot");
    end
    tm.hold(1'b0);
  endtask
  // power-down keeps ready, wake wait, then soft resets
  task t_soft();
    wrc(1'b0, MODE_PWR_DOWN, 4'h3, 4'h3);
    chk(rdy === 1'b1 && aon === 1'b0, "pd keep");
    wrc(1'b0, MODE_CONT_BOTH, 4'h3, 4'h3);
    n = 0;
    while (smp !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 5 && n < 100 && aon === 1'b1, "wake");
    awd = '1;
    aw = 1'b1;
    @(negedge clk);
    aw = 1'b0;
    chk(al === '1, "alarm set");
    rds();
    chk(alert === 1'b0, "alert read clear");
    flt = 1'b1;
    @(negedge clk);
    flt = 1'b0;
    chk(alert === 1'b1, "fault alert");
    gc = 1'b1;
    @(negedge clk);
    gc = 1'b0;
    t_reset();
    wrc(1'b0, MODE_TRIG_BUS, 4'h9, 4'h9);
    chk(cfg.mode === MODE_TRIG_BUS, "trig bus");
    wrc(1'b1, MODE_TRIG_BUS, 4'h9, 4'h9);
    t_reset();
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // stimulus changes only at falling edges
  initial begin
    n_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    gc = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    aw = 1'b0;
    wd = '0;
    awd = '0;
    sh = '0;
    bv = 16'h0123;
    cal = 16'sh0002;
    flt = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_cont();
    t_trig();
    t_held();
    t_soft();
    conclude();
  end
endmodule
